// ==== shared/cwsd_pkg.sv ====
// constants, field layouts and carriers for the complementary wave shutdown block
// assumes one 125 MHz clock and an 8-bit register port with 3 address bits
package cwsd_pkg;

  // register port widths and offsets
  localparam int       DW       = 8;
  localparam int       AW       = 3;
  localparam int       DB_W     = 6;
  localparam logic [2:0] OFS_CTRL = 3'h0;
  localparam logic [2:0] OFS_LVL  = 3'h1;
  localparam logic [2:0] OFS_SHD  = 3'h2;
  localparam logic [2:0] OFS_DBR  = 3'h3;
  localparam logic [2:0] OFS_DBF  = 3'h4;
  localparam logic [2:0] OFS_STAT = 3'h5;

  // field positions
  localparam int CTRL_EN_BIT   = 7;
  localparam int CTRL_POLB_BIT = 5;
  localparam int CTRL_POLA_BIT = 4;
  localparam int LVL_GAP_BIT   = 3;
  localparam int SHD_REQ_BIT   = 7;
  localparam int SHD_AUTO_BIT  = 6;

  // writable masks and reset values
  localparam logic [7:0] CTRL_MASK = 8'hB0;
  localparam logic [7:0] LVL_MASK  = 8'hF7;
  localparam logic [7:0] SHD_MASK  = 8'h47;
  localparam logic [7:0] CTRL_RST  = 8'h00;
  localparam logic [7:0] LVL_RST   = 8'h00;
  localparam logic [7:0] SHD_RST   = 8'h00;
  localparam logic [5:0] DB_RST    = 6'h00;

  // timing: input edges are asynchronous, so dead band may stretch by this much
  localparam int CLK_PERIOD_NS = 8;
  localparam int DB_UNCERT_NS  = 8;
  localparam int DB_UNCERT_CYC = (DB_UNCERT_NS / CLK_PERIOD_NS < 1) ? 1
                                 : DB_UNCERT_NS / CLK_PERIOD_NS;

  // input source codes
  typedef enum logic [2:0] {
    SRC_CMP1 = 3'h0, SRC_CMP2 = 3'h1, SRC_MOD1 = 3'h2, SRC_MOD2 = 3'h3,
    SRC_MOD3 = 3'h4, SRC_MOD4 = 3'h5, SRC_PIN  = 3'h6, SRC_RSVD = 3'h7
  } cwsd_src_e;

  // shutdown override level codes
  typedef enum logic [1:0] {
    LVL_INACT = 2'h0, LVL_TRI = 2'h1, LVL_LOW = 2'h2, LVL_HIGH = 2'h3
  } cwsd_lvl_e;

  // shutdown_level_and_source_control layout
  typedef struct packed {
    cwsd_lvl_e lvl_b;
    cwsd_lvl_e lvl_a;
    logic      gap;
    cwsd_src_e src;
  } cwsd_lvl_s;

  // asynchronous inputs from comparators, modulators and pins
  typedef struct packed {
    logic       fault;
    logic       cmp2;
    logic       cmp1;
    logic       in_pin;
    logic [3:0] mod;
  } cwsd_pins_s;

endpackage

// ==== rtl/cwsd_top.sv ====
// complementary wave generator with input selection, dead band and auto-shutdown
// assumes all source inputs are asynchronous and the register master never waits
//
// Chosen here: the register addresses and strobed register access.
`timescale 1ns/1ns
module cwsd_top (
  // clock and reset
  input  wire logic                   CORE_CLK,
  input  wire logic                   RST_N,
  // register port
  input  wire logic [cwsd_pkg::AW-1:0] REG_ADDR,
  input  wire logic [cwsd_pkg::DW-1:0] REG_WDATA,
  input  wire logic                   REG_WR,
  input  wire logic                   REG_RD,
  output logic      [cwsd_pkg::DW-1:0] REG_RDATA,
  // asynchronous sources
  input  wire cwsd_pkg::cwsd_pins_s   SRC_IN,
  // waveform outputs, enable high while driven
  output logic                        WAVE_A_O,
  output logic                        WAVE_A_OE,
  output logic                        WAVE_B_O,
  output logic                        WAVE_B_OE,
  // shutdown state
  output logic                        SHUTDOWN_ACTIVE
);

  typedef enum logic [1:0] {DB_DEAD = 2'b01, DB_DRIVE = 2'b10} cwsd_db_e;

  cwsd_pkg::cwsd_pins_s pins_s1_reg;
  cwsd_pkg::cwsd_pins_s pins_reg;
  cwsd_pkg::cwsd_lvl_s  lvl_reg;
  logic [7:0]           ctrl_reg;
  logic                 auto_reg;
  logic [2:0]           src_en_reg;
  logic                 req_reg;
  logic                 req_next;
  logic [5:0]           dbr_reg;
  logic [5:0]           dbf_reg;
  logic [5:0]           cnt_reg;
  logic [5:0]           db_load;
  cwsd_db_e             db_reg;
  logic                 drive_now;
  logic                 sel_in;
  logic                 sel_prev_reg;
  logic                 edge_ev;
  logic                 rise_ev;
  logic                 ext_active;
  logic                 shut;
  logic                 gen_en;
  logic                 a_raw;
  logic                 b_raw;
  logic [1:0]           a_next;
  logic [1:0]           b_next;
  logic                 wr_shd;

  // pick the generator input; the reserved code gives a quiet low
  function automatic logic src_pick(cwsd_pkg::cwsd_src_e s, cwsd_pkg::cwsd_pins_s p);
    unique case (s)
      cwsd_pkg::SRC_CMP1: src_pick = p.cmp1;
      cwsd_pkg::SRC_CMP2: src_pick = p.cmp2;
      cwsd_pkg::SRC_MOD1: src_pick = p.mod[0];
      cwsd_pkg::SRC_MOD2: src_pick = p.mod[1];
      cwsd_pkg::SRC_MOD3: src_pick = p.mod[2];
      cwsd_pkg::SRC_MOD4: src_pick = p.mod[3];
      cwsd_pkg::SRC_PIN:  src_pick = p.in_pin;
      default:            src_pick = 1'b0;
    endcase
  endfunction

  // output value for one leg: {enable, level}
  function automatic logic [1:0] leg(logic shd, cwsd_pkg::cwsd_lvl_e l, logic raw,
                                     logic pol);
    if (!shd) begin
      leg = {1'b1, raw ^ pol};
    end else begin
      unique case (l)
        cwsd_pkg::LVL_HIGH: leg = 2'b11;
        cwsd_pkg::LVL_LOW:  leg = 2'b10;
        cwsd_pkg::LVL_TRI:  leg = 2'b00;
        default:            leg = {1'b1, pol};
      endcase
    end
  endfunction

  function automatic logic hit(logic s, logic [2:0] a, logic [2:0] ofs);
    hit = s && (a == ofs);
  endfunction

  // two-stage synchroniser; stage one feeds stage two only
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      pins_s1_reg <= '0;
      pins_reg    <= '0;
    end else begin
      pins_s1_reg <= SRC_IN;
      pins_reg    <= pins_s1_reg;
    end
  end

  // input selection and edge detection on synchronised levels
  assign sel_in  = src_pick(lvl_reg.src, pins_reg);
  assign edge_ev = sel_in != sel_prev_reg;
  assign rise_ev = sel_in && !sel_prev_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      sel_prev_reg <= 1'b0;
    end else begin
      sel_prev_reg <= sel_in;
    end
  end

  // enabled sources are ORed as levels, so any mix can hold shutdown
  assign ext_active = |(src_en_reg & {pins_reg.fault, pins_reg.cmp2, pins_reg.cmp1});
  assign shut       = req_reg || ext_active;
  assign gen_en     = ctrl_reg[cwsd_pkg::CTRL_EN_BIT];
  assign wr_shd     = hit(REG_WR, REG_ADDR, cwsd_pkg::OFS_SHD);

  // general control: enable and polarities
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      ctrl_reg <= cwsd_pkg::CTRL_RST;
    end else if (hit(REG_WR, REG_ADDR, cwsd_pkg::OFS_CTRL)) begin
      ctrl_reg <= REG_WDATA & cwsd_pkg::CTRL_MASK;
    end
  end

  // level and source control; the gap bit never stores
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      lvl_reg <= cwsd_pkg::LVL_RST;
    end else if (hit(REG_WR, REG_ADDR, cwsd_pkg::OFS_LVL)) begin
      lvl_reg <= REG_WDATA & cwsd_pkg::LVL_MASK;
    end
  end

  // restart mode and source enables
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      auto_reg   <= cwsd_pkg::SHD_RST[cwsd_pkg::SHD_AUTO_BIT];
      src_en_reg <= cwsd_pkg::SHD_RST[2:0];
    end else if (wr_shd) begin
      auto_reg   <= REG_WDATA[cwsd_pkg::SHD_AUTO_BIT];
      src_en_reg <= REG_WDATA[2:0];
    end
  end

  // dead-band lengths in clock cycles
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      dbr_reg <= cwsd_pkg::DB_RST;
      dbf_reg <= cwsd_pkg::DB_RST;
    end else begin
      if (hit(REG_WR, REG_ADDR, cwsd_pkg::OFS_DBR)) begin
        dbr_reg <= REG_WDATA[5:0];
      end
      if (hit(REG_WR, REG_ADDR, cwsd_pkg::OFS_DBF)) begin
        dbf_reg <= REG_WDATA[5:0];
      end
    end
  end

  // request bit: an active source outranks every clear, set outranks clear
  always_comb begin
    req_next = req_reg;
    if (ext_active) begin
      req_next = 1'b1;
    end else if (wr_shd && REG_WDATA[cwsd_pkg::SHD_REQ_BIT]) begin
      req_next = 1'b1;
    end else if (wr_shd) begin
      req_next = 1'b0;
    end else if (auto_reg && rise_ev) begin
      req_next = 1'b0;
    end
  end

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      req_reg <= cwsd_pkg::SHD_RST[cwsd_pkg::SHD_REQ_BIT];
    end else begin
      req_reg <= req_next;
    end
  end

  // dead band: every input edge restarts the gap; synchroniser makes it +-1 cycle
  assign db_load = sel_in ? dbr_reg : dbf_reg;

  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      db_reg  <= DB_DEAD;
      cnt_reg <= '0;
    end else if (edge_ev) begin
      db_reg  <= (db_load == 6'h00) ? DB_DRIVE : DB_DEAD;
      cnt_reg <= (db_load == 6'h00) ? 6'h00 : db_load - 6'h01;
    end else begin
      unique case (db_reg)
        DB_DEAD: begin
          if (cnt_reg == 6'h00) begin
            db_reg <= DB_DRIVE;
          end else begin
            cnt_reg <= cnt_reg - 6'h01;
          end
        end
        DB_DRIVE: db_reg <= DB_DRIVE;
        default:  db_reg <= DB_DEAD;
      endcase
    end
  end

  // legs stay off in the edge cycle itself if the new gap is non-zero, or the old drive state would let
  // the new leg through for one cycle before the gap opens
  assign drive_now = edge_ev ? (db_load == 6'h00) : (db_reg == DB_DRIVE);
  assign a_raw     = drive_now && sel_in;
  assign b_raw     = drive_now && !sel_in;

  // override or normal drive; a disabled generator floats both legs
  assign a_next = gen_en ? leg(shut, lvl_reg.lvl_a, a_raw,
                               ctrl_reg[cwsd_pkg::CTRL_POLA_BIT]) : 2'b00;
  assign b_next = gen_en ? leg(shut, lvl_reg.lvl_b, b_raw,
                               ctrl_reg[cwsd_pkg::CTRL_POLB_BIT]) : 2'b00;

  // registered pins keep glitches off the power stage
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      {WAVE_A_OE, WAVE_A_O} <= 2'b00;
      {WAVE_B_OE, WAVE_B_O} <= 2'b00;
      SHUTDOWN_ACTIVE       <= 1'b0;
    end else begin
      {WAVE_A_OE, WAVE_A_O} <= a_next;
      {WAVE_B_OE, WAVE_B_O} <= b_next;
      SHUTDOWN_ACTIVE       <= shut;
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge CORE_CLK) begin
    if (!RST_N) begin
      REG_RDATA <= '0;
    end else if (REG_RD) begin
      unique case (REG_ADDR)
        cwsd_pkg::OFS_CTRL: REG_RDATA <= ctrl_reg;
        cwsd_pkg::OFS_LVL:  REG_RDATA <= lvl_reg;
        cwsd_pkg::OFS_SHD:  REG_RDATA <= {req_reg, auto_reg, 3'h0, src_en_reg};
        cwsd_pkg::OFS_DBR:  REG_RDATA <= {2'h0, dbr_reg};
        cwsd_pkg::OFS_DBF:  REG_RDATA <= {2'h0, dbf_reg};
        cwsd_pkg::OFS_STAT: REG_RDATA <= {shut, ext_active, db_reg == DB_DRIVE, sel_in,
                                          WAVE_A_OE, WAVE_A_O, WAVE_B_OE, WAVE_B_O};
        default:            REG_RDATA <= '0;
      endcase
    end else begin
      REG_RDATA <= '0;
    end
  end

  // checks on the design's own behaviour
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!RST_N);

  sequence s_edge_gap;
    edge_ev && (db_load > 6'h01);
  endsequence

  sequence s_quiet_gap;
    (db_reg == DB_DEAD) && !a_raw && !b_raw;
  endsequence

  // restart edge taken with no source holding the request
  sequence s_restart;
    req_reg && auto_reg && rise_ev && !ext_active && !wr_shd;
  endsequence

  a_dead_gap: assert property (s_edge_gap |-> (!a_raw && !b_raw) ##1 s_quiet_gap [*2])
    else $error("dead band did not hold both legs off");

  a_sw_enter: assert property (wr_shd && REG_WDATA[cwsd_pkg::SHD_REQ_BIT]
                               |=> req_reg ##1 SHUTDOWN_ACTIVE)
    else $error("software request did not enter shutdown");

  a_sw_exit: assert property (wr_shd && !REG_WDATA[cwsd_pkg::SHD_REQ_BIT] && !ext_active
                              |=> !req_reg)
    else $error("software clear did not leave shutdown");

  a_hold_manual: assert property (req_reg && !auto_reg && !wr_shd |=> req_reg)
    else $error("request dropped without software or restart");

  a_auto_clear: assert property (s_restart |=> !req_reg)
    else $error("auto restart did not clear request");

  a_resume_out: assert property (s_restart ##1 !ext_active |=> !SHUTDOWN_ACTIVE)
    else $error("outputs did not resume after auto restart");

  a_src_hold: assert property (ext_active |=> req_reg)
    else $error("active source did not hold request");

  a_src_enter: assert property (ext_active |=> SHUTDOWN_ACTIVE)
    else $error("active source did not enter shutdown");

  a_no_release: assert property ($fell(req_reg) |-> !$past(ext_active))
    else $error("request cleared while source active");

  a_fault_low: assert property (ext_active && gen_en && lvl_reg.lvl_b == cwsd_pkg::LVL_LOW
                                |=> WAVE_B_OE && !WAVE_B_O)
    else $error("fault did not force output B low");

  a_shut_high: assert property (shut && gen_en && lvl_reg.lvl_a == cwsd_pkg::LVL_HIGH
                                |=> WAVE_A_OE && WAVE_A_O)
    else $error("output A not forced high in shutdown");

  a_low_a: assert property (shut && gen_en && lvl_reg.lvl_a == cwsd_pkg::LVL_LOW
                            |=> WAVE_A_OE && !WAVE_A_O)
    else $error("output A not forced low in shutdown");

  a_shut_tri: assert property (shut && gen_en && lvl_reg.lvl_b == cwsd_pkg::LVL_TRI
                               |=> !WAVE_B_OE)
    else $error("output B not released in shutdown");

  a_inact_b: assert property (shut && gen_en && lvl_reg.lvl_b == cwsd_pkg::LVL_INACT
                              |=> WAVE_B_OE
                                  && (WAVE_B_O == $past(ctrl_reg[cwsd_pkg::CTRL_POLB_BIT])))
    else $error("output B not at its inactive level in shutdown");

  a_gap_zero: assert property (REG_RD && REG_ADDR == cwsd_pkg::OFS_LVL
                               |=> !REG_RDATA[cwsd_pkg::LVL_GAP_BIT])
    else $error("unimplemented bit read as one");

  // the pins carry the polarity of the cycle before, so compare against that
  a_one_legged: assert property (gen_en && !shut
                                 |=> !((WAVE_A_O ^ $past(ctrl_reg[cwsd_pkg::CTRL_POLA_BIT]))
                                 && (WAVE_B_O ^ $past(ctrl_reg[cwsd_pkg::CTRL_POLB_BIT]))))
    else $error("both legs active together");

endmodule

// ==== tb/cwsd_stage.sv ====
// model of the power switching stage driven by outputs A and B
// assumes A drives the high-side gate and B the low-side gate of one half bridge
`timescale 1ns/1ns
module cwsd_stage (
  // clock
  input  wire logic clk,
  // gate drive from the block
  input  wire logic a_o,
  input  wire logic a_oe,
  input  wire logic b_o,
  input  wire logic b_oe,
  // bench control and observation
  input  wire logic arm,
  output int        overlap
);
  logic gate_hi;
  logic gate_lo;

  // an undriven gate is held off by its pull-down, never by the last level
  assign gate_hi = a_oe ? a_o : 1'b0;
  assign gate_lo = b_oe ? b_o : 1'b0;

  // both switches on at once shorts the rail; forced override levels may do
  // that on purpose, so the bench only arms this in normal running
  initial overlap = 0;
  always @(posedge clk) begin
    if (arm && gate_hi && gate_lo) begin
      overlap <= overlap + 1;
    end
  end
endmodule

// ==== tb/tb_cwsd_top.sv ====
// self-checking bench for the complementary wave shutdown block
// assumes the package and the stage model are compiled before this file
`timescale 1ns/1ns
module tb_cwsd_top;
  logic       CORE_CLK    = 1'b0;
  logic       RST_N       = 1'b0;
  logic [2:0] addr        = 3'h0;
  logic [7:0] wdata       = 8'h00;
  logic       wr          = 1'b0;
  logic       rd          = 1'b0;
  logic [7:0] srcv        = 8'h00;
  logic       arm         = 1'b0;
  logic [7:0] rdata;
  logic       a_o;
  logic       a_oe;
  logic       b_o;
  logic       b_oe;
  logic       shut;
  int         overlap;
  int         miscompares = 0;
  int         checked     = 0;
  int         cycles      = 0;
  int         sbit[7]     = '{5, 6, 0, 1, 2, 3, 4};

  // 125 MHz core clock
  always #4 CORE_CLK = ~CORE_CLK;

  cwsd_top i_cwsd_top (
    .CORE_CLK        (CORE_CLK),
    .RST_N           (RST_N),
    .REG_ADDR        (addr),
    .REG_WDATA       (wdata),
    .REG_WR          (wr),
    .REG_RD          (rd),
    .REG_RDATA       (rdata),
    .SRC_IN          (cwsd_pkg::cwsd_pins_s'(srcv)),
    .WAVE_A_O        (a_o),
    .WAVE_A_OE       (a_oe),
    .WAVE_B_O        (b_o),
    .WAVE_B_OE       (b_oe),
    .SHUTDOWN_ACTIVE (shut)
  );

  cwsd_stage i_cwsd_stage (
    .clk     (CORE_CLK),
    .a_o     (a_o),
    .a_oe    (a_oe),
    .b_o     (b_o),
    .b_oe    (b_oe),
    .arm     (arm),
    .overlap (overlap)
  );

  task automatic stop_test();
    if (miscompares == 0 && checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // a hang counts as a mismatch; the full run needs well under 3000 cycles
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test();
    end
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge CORE_CLK);
  endtask

  task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wr_reg(input logic [2:0] a, input logic [7:0] d);
    @(posedge CORE_CLK);
    wr    <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge CORE_CLK);
    wr    <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe, so sample there
  task automatic chk_reg(input logic [2:0] a, input logic [7:0] exp);
    @(posedge CORE_CLK);
    rd   <= 1'b1;
    addr <= a;
    @(posedge CORE_CLK);
    rd   <= 1'b0;
    #2;
    chk_val(rdata, exp);
  endtask

  // pins as {shutdown, A enable, A level, B enable, B level}
  task automatic chk_pins(input logic [4:0] exp, input logic [4:0] mask);
    #1;
    chk_val({3'h0, {shut, a_oe, a_o, b_oe, b_o} & mask}, {3'h0, exp & mask});
  endtask

  task automatic pin(input int b, input logic v);
    @(posedge CORE_CLK);
    srcv[b] <= v;
  endtask

  // expected {enable, level} of one output for a shutdown level code
  function automatic logic [1:0] lvl_pins(input logic [1:0] code, input logic pol);
    case (code)
      2'h3: return 2'b11;
      2'h2: return 2'b10;
      2'h1: return 2'b00;
      default: return {1'b1, pol};
    endcase
  endfunction

  initial begin
    cyc(8);
    RST_N <= 1'b1;
    cyc(1);
    chk_pins(5'h00, 5'h1F);
    for (int i = 0; i < 8; i++) begin
      chk_reg(i[2:0], (i == 5) ? 8'h20 : 8'h00); // idle status shows the drive state
    end
    wr_reg(3'h1, 8'hFE);
    chk_reg(3'h1, 8'hF6);
    wr_reg(3'h7, 8'hFF);
    chk_reg(3'h7, 8'h00);
    // every defined input source code; the reserved code is never programmed
    wr_reg(3'h0, 8'h80);
    arm <= 1'b1;
    for (int c = 0; c < 7; c++) begin
      wr_reg(3'h1, {5'h00, c[2:0]});
      pin(sbit[c], 1'b1);
      cyc(6);
      chk_pins(5'h0E, 5'h1F);
      pin(sbit[c], 1'b0);
      cyc(6);
      chk_pins(5'h0B, 5'h1F);
    end
    // rising gap of two counts, allowing one cycle of edge jitter
    wr_reg(3'h1, 8'h06);
    wr_reg(3'h3, 8'h02);
    pin(4, 1'b1);
    cyc(4);
    chk_pins(5'h0A, 5'h1F);
    cyc(3);
    chk_pins(5'h0E, 5'h1F);
    pin(4, 1'b0);
    wr_reg(3'h3, 8'h00);
    cyc(4);
    arm <= 1'b0;
    chk_val(overlap[7:0], 8'h00);
    // software shutdown through all level codes, A polarity inverted
    wr_reg(3'h0, 8'h90);
    wr_reg(3'h2, 8'h80);
    for (int la = 0; la < 4; la++) begin
      wr_reg(3'h1, {~la[1:0], la[1:0], 4'h6});
      cyc(2);
      chk_pins({1'b1, lvl_pins(la[1:0], 1'b1), lvl_pins(~la[1:0], 1'b0)},
               {2'b11, la != 1, 1'b1, la != 2});
    end
    chk_reg(3'h2, 8'h80);
    wr_reg(3'h2, 8'h00);
    cyc(3);
    chk_pins(5'h0F, 5'h1F);
    wr_reg(3'h0, 8'h80);
    // automatic restart on the next rising input edge
    wr_reg(3'h2, 8'hC0);
    cyc(10);
    chk_pins(5'h10, 5'h10);
    pin(4, 1'b1);
    cyc(6);
    chk_pins(5'h0E, 5'h1F);
    chk_reg(3'h2, 8'h40);
    pin(4, 1'b0);
    cyc(6);
    // each external source alone, level held against clear and restart
    // both legs forced low while a source holds shutdown
    wr_reg(3'h1, 8'hA6);
    for (int i = 0; i < 3; i++) begin
      wr_reg(3'h2, 8'h40 | (8'h01 << i));
      pin(5 + i, 1'b1);
      cyc(4);
      chk_pins(5'h1A, 5'h1F);
      chk_reg(3'h2, 8'hC0 | (8'h01 << i));
      wr_reg(3'h2, 8'h40 | (8'h01 << i));
      pin(4, 1'b1);
      cyc(4);
      chk_pins(5'h1A, 5'h1F);
      pin(4, 1'b0);
      pin(5 + i, 1'b0);
      cyc(3);
      pin(4, 1'b1);
      cyc(6);
      chk_pins(5'h0E, 5'h1F);
      pin(4, 1'b0);
      cyc(6);
    end
    stop_test();
  end
endmodule
